// *** bench/clock_consumer_model.sv ***
// peripheral model that takes the fixed-frequency clock as its source
// assumes the clock block's power outputs and sampling on clk_sys
`timescale 1ns/1ps
`default_nettype none
module clock_consumer_model (
	input  wire logic                  clk_sys,
	input  wire logic                  rst,
	input  wire logic                  fixed_freq_clock,
	input  wire fll_clock_pkg::power_s power,
	output var int                     ff_rises
);
	logic ff_prev;
	logic use_ok;
	// ------------------------------------------
	// source select
	// ------------------------------------------
	// clock is off in internal-engaged and self-clocked schemes, so stay off it
	assign use_ok = !(power.irg_on || power.dco_open_loop);
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			ff_prev  <= 1'h0;
			ff_rises <= 0;
		end
		else
		begin
			ff_prev <= fixed_freq_clock;
			if (use_ok && fixed_freq_clock && !ff_prev)
				ff_rises <= ff_rises + 1;
		end
	end
endmodule
`default_nettype wire

// *** bench/fll_clock_generator_test.sv ***
// self-checking bench of the clock generation control block
// assumes the consumer model and a free external reference slower than clk_sys/4
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_count++; \
	$display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module fll_clock_generator_test;
	localparam int BH = 2;
	logic                      clk_sys = 1'h0;
	logic                      rst = 1'h1;
	fll_clock_pkg::wb_req_s    wb_req = '0;
	fll_clock_pkg::wb_rsp_s    wb_rsp;
	logic                      external_ref_clock = 1'h0;
	logic                      loop_lock = 1'h0;
	logic                      internal_bus_clock;
	logic                      fixed_freq_clock;
	logic                      fixed_freq_enable;
	fll_clock_pkg::freq_cfg_s  generator_cfg;
	fll_clock_pkg::power_s     power;
	logic                      oscillator_high_gain;
	logic                      rti_ref_clock;
	logic                      alternate_converter_clock;
	logic                      local_self_clock;
	int                        err_count = 0;
	int                        check_count = 0;
	int                        ff_rises;
	int                        rises[6] = '{default: 0};
	logic [5:0]                prev = '0;
	logic [5:0]                cur;
	logic                      ff_last = 1'h0;
	int                        run = 1;
	int                        min_run = 99;
	int                        ref_cnt = 0;

	fll_clock_generator #(.BUS_HALF(BH), .SELF_HALF(1)) dut (.clk_sys(clk_sys), .rst(rst), .wb_req(wb_req),
		.wb_rsp(wb_rsp), .external_ref_clock(external_ref_clock), .loop_lock(loop_lock),
		.internal_bus_clock(internal_bus_clock), .fixed_freq_clock(fixed_freq_clock),
		.fixed_freq_enable(fixed_freq_enable), .generator_cfg(generator_cfg), .power(power),
		.oscillator_high_gain(oscillator_high_gain), .rti_ref_clock(rti_ref_clock),
		.alternate_converter_clock(alternate_converter_clock), .local_self_clock(local_self_clock));
	clock_consumer_model peer (.clk_sys(clk_sys), .rst(rst), .fixed_freq_clock(fixed_freq_clock),
		.power(power), .ff_rises(ff_rises));

	// ------------------------------------------
	// clocks and edge counters
	// ------------------------------------------
	always #25 clk_sys = ~clk_sys;
	// reference at clk_sys/10, well below the clk_sys/4 sampling limit
	always @(posedge clk_sys)
	begin
		ref_cnt <= (ref_cnt == 4) ? 0 : ref_cnt + 1;
		if (ref_cnt == 4)
			external_ref_clock <= ~external_ref_clock;
	end
	assign cur = {fixed_freq_clock, internal_bus_clock, external_ref_clock, rti_ref_clock,
		alternate_converter_clock, local_self_clock};
	always @(posedge clk_sys)
	begin
		prev <= cur;
		for (int i = 0; i < 6; i++)
			if (cur[i] && !prev[i])
				rises[i] <= rises[i] + 1;
		ff_last <= fixed_freq_clock;
		if (fixed_freq_clock === ff_last)
			run <= run + 1;
		else
		begin
			if (run < min_run)
				min_run <= run;
			run <= 1;
		end
	end

	// ------------------------------------------
	// bus tasks and scenarios
	// ------------------------------------------
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] q);
		int n;
		@(posedge clk_sys);
		wb_req <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: a, sel: s, dat: d};
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (wb_rsp.ack !== 1'h1);
		`CHK("wb_latency", 2, n)
		q = wb_rsp.dat;
		wb_req <= '0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] q;
		wb(1'h1, a, d, s, q);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		wb(1'h0, a, 32'h0, 4'hF, q);
	endtask
	task automatic win(input int n, output int d[6], output int f);
		int s[6];
		int sf;
		s = rises;
		sf = ff_rises;
		repeat (n) @(posedge clk_sys);
		foreach (d[i]) d[i] = rises[i] - s[i];
		f = ff_rises - sf;
	endtask
	task automatic rst_pulse;
		@(posedge clk_sys);
		rst <= 1'h1;
		repeat (8) @(posedge clk_sys);
		rst <= 1'h0;
	endtask
	task automatic t_reset_values;
		logic [31:0] q;
		int d[6];
		int f;
		rd(8'h04, q);
		`CHK("status_rst", 32'h0000_0418, q)
		rd(8'h08, q);
		`CHK("freq_rst", 32'h0001_0001, q)
		win(40, d, f);
		`CHK("ff_scm", 0, d[5])
		`CHK("self_clk", 20, d[0])
	endtask
	task automatic t_high_gain;
		logic [31:0] q;
		wr(8'h00, 32'h0000_0012, 4'h1);
		repeat (3) @(posedge clk_sys);
		`CHK("hgo_refs0", 1'h0, oscillator_high_gain)
		wr(8'h00, 32'h0000_000A, 4'h1);
		repeat (3) @(posedge clk_sys);
		`CHK("hgo_once", 1'h1, oscillator_high_gain)
		rst_pulse();
		rd(8'h00, q);
		`CHK("hgo_rst", 1'h0, q[4])
		wr(8'h00, 32'h0000_0018, 4'h1);
		repeat (3) @(posedge clk_sys);
		`CHK("hgo_on", 1'h1, oscillator_high_gain)
	endtask
	task automatic t_decode;
		logic [31:0] q;
		int d[6];
		int f;
		for (int k = 0; k < 5; k++)
		begin
			wr(8'h00, {17'h0, k[2:0], 1'h0, k[2:0], 8'h02}, 4'h3);
			rd(8'h04, q);
			`CHK("n_dec", 4'(4 + 2 * k), q[11:8])
			`CHK("r_dec", k[2:0], q[14:12])
			rd(8'h08, q);
			`CHK("freq_fbe", 32'h1001_0001 | (k << 24), q)
		end
		`CHK("pwr_fbe", 3'h0, power)
		wr(8'h00, 32'h0000_7702, 4'h3);
		rd(8'h00, q);
		`CHK("raw_rsv", 32'h0000_7712, q)
		rd(8'h04, q);
		`CHK("kept_rsv", 7'h4C, {q[14:12], q[11:8]})
		win(40, d, f);
		`CHK("ff_fbe", d[4], d[5])
		`CHK("bus_rate", 40 / (2 * BH), d[4])
	endtask
	task automatic t_fei;
		logic [31:0] q;
		int d[6];
		int f;
		wr(8'h00, 32'h0000_1201, 4'h3);
		repeat (20) @(posedge clk_sys);
		win(40, d, f);
		`CHK("ff_fei", 0, d[5])
		rd(8'h08, q);
		`CHK("freq_fei", 32'h2107_0200, q)
		`CHK("pwr_fei", 3'h6, power)
		`CHK("cfg_fei", {2'h2, 10'h200, 4'h7, 3'h1}, generator_cfg)
	endtask
	task automatic t_fee;
		logic [31:0] q;
		int d[6];
		int f;
		loop_lock <= 1'h1;
		min_run <= 99;
		wr(8'h00, 32'h0000_0003, 4'h3);
		repeat (8) @(posedge clk_sys);
		`CHK("ffe_p64", 1'h1, fixed_freq_enable)
		rd(8'h08, q);
		`CHK("freq_fee", 32'h1001_0100, q)
		`CHK("pwr_fee", 3'h2, power)
		win(168, d, f);
		`CHK("ff_half", 1'h1, f >= d[3] / 2 - 1 && f <= d[3] / 2 + 1)
		wr(8'h00, 32'h0000_0007, 4'h1);
		rd(8'h08, q);
		`CHK("freq_p1", 32'h1001_0004, q)
		`CHK("ffe_edge", 1'h1, fixed_freq_enable)
		wr(8'h00, 32'h0000_1007, 4'h3);
		`CHK("ffe_low", 1'h0, fixed_freq_enable)
		repeat (20) @(posedge clk_sys);
		win(40, d, f);
		`CHK("ff_bus_fee", d[4], d[5])
		wr(8'h00, 32'h0000_0003, 4'h3);
		loop_lock <= 1'h0;
		repeat (6) @(posedge clk_sys);
		`CHK("ffe_unlock", 1'h0, fixed_freq_enable)
		`CHK("ff_glitch", 1'h1, min_run >= BH)
	endtask
	task automatic t_aux;
		logic [31:0] q;
		logic [31:0] q0;
		int d[6];
		int f;
		rd(8'h00, q0);
		wr(8'h0C, 32'hFFFF_FFFF, 4'hF);
		wr(8'h04, 32'hFFFF_FFFF, 4'hF);
		rd(8'h00, q);
		`CHK("ctrl_kept", q0, q)
		rd(8'h0C, q);
		`CHK("unmapped_rd", 32'h0, q)
		win(168, d, f);
		`CHK("rti_clk", 1'h1, d[2] >= d[3] - 1 && d[2] <= d[3] + 1)
		`CHK("alt_clk", 1'h1, d[1] >= d[3] - 1 && d[1] <= d[3] + 1)
	endtask
	task automatic results;
		if (err_count == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		rst_pulse();
		t_reset_values();
		t_high_gain();
		t_decode();
		t_fei();
		t_fee();
		t_aux();
		results();
	end
	// about seven hundred cycles expected; generous margin
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		err_count++;
		results();
	end
endmodule
`default_nettype wire

// *** src/fll_clock_generator.sv ***
// clock generation control: scheme select, factor decode, fixed-frequency clock, oscillator gain option
// assumes a classic Wishbone master on clk_sys and asynchronous reference and lock pins
//
// Operation
// - fixed-frequency clock follows bus clock in bypassed external, and in loop-engaged external when not enabled.
// - in loop-engaged external, half reference when P*N/R at least 4 and locked.
// - fixed-frequency clock is off in loop-engaged internal and self-clocked schemes.
// - high gain select picks oscillator gain, honoured only when reference select is 1.
// - high gain select accepts one write after reset, later writes ignored.
// - multiplier field 000..100 decodes to n of 4, 6, 8, 10, 12.
// - divider field 000..100 decodes to divide by 1, 2, 4, 8, 16.
// - self-clocked gives oscillator over R; bypassed external gives reference over R.
// - loop-engaged internal gives internal reference over 7, times 64, n, over R.
// - loop-engaged external gives reference times P times n over R; P by range.
// - power of reference generator and oscillator set per scheme.
// - external reference offered to interrupt timer and converter alternate clock.
// - local self clock near 10 MHz (clk_sys over 2*SELF_HALF) offered to debug tools.
`timescale 1ns/1ps
`default_nettype none

module fll_clock_generator #(
	parameter int BUS_HALF  = 2,
	parameter int SELF_HALF = 1
) (
	input  wire logic                      clk_sys,
	input  wire logic                      rst,
	input  wire fll_clock_pkg::wb_req_s    wb_req,
	output fll_clock_pkg::wb_rsp_s         wb_rsp,
	input  wire logic                      external_ref_clock,
	input  wire logic                      loop_lock,
	output logic                           internal_bus_clock,
	output logic                           fixed_freq_clock,
	output logic                           fixed_freq_enable,
	output fll_clock_pkg::freq_cfg_s       generator_cfg,
	output fll_clock_pkg::power_s          power,
	output logic                           oscillator_high_gain,
	output logic                           rti_ref_clock,
	output logic                           alternate_converter_clock,
	output logic                           local_self_clock
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		fll_clock_pkg::scheme_e   scheme;
		logic                     range_sel;
		logic                     reference_select;
		logic                     high_gain_select;
		logic                     hgo_done;
		logic [2:0]               multiplier_field;
		logic [2:0]               divider_field;
		logic [3:0]               n_fac;
		logic [2:0]               r_shift;
		logic                     ext_s1;
		logic                     ext_s2;
		logic                     ext_s3;
		logic                     lock_s1;
		logic                     lock_s2;
		logic [7:0]               bus_cnt;
		logic                     bus_clk;
		logic [7:0]               self_cnt;
		logic                     self_clk;
		logic                     half_ref;
		fll_clock_pkg::ff_sel_e   ff_sel;
		logic                     ff_hold;
		logic                     ff_clk;
		logic                     hgo_eff;
		fll_clock_pkg::freq_cfg_s cfg;
		fll_clock_pkg::power_s    pwr;
		logic                     ack;
		logic [31:0]              rdat;
	} state_s;

	state_s s_q;
	state_s s_d;

	logic                   ffe;
	logic [9:0]             p_fac;
	logic [9:0]             pn;
	logic [9:0]             four_r;
	logic                   access;
	logic                   wr_ctrl0;
	logic                   wr_ctrl1;
	logic                   cur_src;
	logic                   new_src;
	fll_clock_pkg::ff_sel_e ff_want;

	// ----------------------------------------------------------------
	// fixed-frequency enable
	// ----------------------------------------------------------------
	// compare P*n against 4*R instead of dividing, no rounding loss
	assign p_fac  = s_q.range_sel ? fll_clock_pkg::P_HIGH_RANGE : fll_clock_pkg::P_LOW_RANGE;
	assign pn     = 10'(p_fac * {6'h00, s_q.n_fac});
	assign four_r = 10'(fll_clock_pkg::FFE_RATIO << s_q.r_shift);
	assign ffe    = (s_q.scheme == fll_clock_pkg::SCHEME_FEE) && (pn >= four_r) && s_q.lock_s2;

	always_comb
	begin
		unique case (s_q.scheme)
			fll_clock_pkg::SCHEME_FEI,
			fll_clock_pkg::SCHEME_SCM: ff_want = fll_clock_pkg::FF_OFF;
			fll_clock_pkg::SCHEME_FEE: ff_want = ffe ? fll_clock_pkg::FF_REF : fll_clock_pkg::FF_BUS;
			fll_clock_pkg::SCHEME_FBE: ff_want = fll_clock_pkg::FF_BUS;
		endcase
	end

	function automatic logic src_level(input fll_clock_pkg::ff_sel_e sel, input logic bus_l, input logic ref_l);
		logic lvl;
		lvl = 1'b0;
		unique case (sel)
			fll_clock_pkg::FF_BUS: lvl = bus_l;
			fll_clock_pkg::FF_REF: lvl = ref_l;
			default:               lvl = 1'b0;
		endcase
		return lvl;
	endfunction

	assign cur_src  = src_level(s_q.ff_sel, s_q.bus_clk, s_q.half_ref);
	assign new_src  = src_level(ff_want, s_q.bus_clk, s_q.half_ref);
	assign access   = wb_req.cyc && wb_req.stb && !s_q.ack;
	assign wr_ctrl0 = access && wb_req.we && (wb_req.adr == fll_clock_pkg::OFF_CTRL) && wb_req.sel[0];
	assign wr_ctrl1 = access && wb_req.we && (wb_req.adr == fll_clock_pkg::OFF_CTRL) && wb_req.sel[1];

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;

		// synchronisers, first stage read only by the second
		s_d.ext_s1  = external_ref_clock;
		s_d.ext_s2  = s_q.ext_s1;
		s_d.ext_s3  = s_q.ext_s2;
		s_d.lock_s1 = loop_lock;
		s_d.lock_s2 = s_q.lock_s1;

		// half reference toggles on each synchronised rising edge
		if (s_q.ext_s2 && !s_q.ext_s3)
		begin
			s_d.half_ref = !s_q.half_ref;
		end

		// bus clock and local self clock dividers
		if (s_q.bus_cnt == 8'(BUS_HALF - 1))
		begin
			s_d.bus_cnt = 8'h00;
			s_d.bus_clk = !s_q.bus_clk;
		end
		else
		begin
			s_d.bus_cnt = s_q.bus_cnt + 8'h01;
		end
		if (s_q.self_cnt == 8'(SELF_HALF - 1))
		begin
			s_d.self_cnt = 8'h00;
			s_d.self_clk = !s_q.self_clk;
		end
		else
		begin
			s_d.self_cnt = s_q.self_cnt + 8'h01;
		end

		// switch only with output and old source low, then hold low until the new one is low
		if (s_q.ff_hold)
		begin
			s_d.ff_clk = 1'b0;
			if (!cur_src)
			begin
				s_d.ff_hold = 1'b0;
			end
		end
		else if ((ff_want != s_q.ff_sel) && !cur_src && !s_q.ff_clk)
		begin
			s_d.ff_sel  = ff_want;
			s_d.ff_hold = new_src;
			s_d.ff_clk  = 1'b0;
		end
		else
		begin
			s_d.ff_clk = cur_src;
		end

		// control register writes
		if (wr_ctrl0)
		begin
			s_d.scheme           = fll_clock_pkg::scheme_e'(wb_req.dat[fll_clock_pkg::CTRL_SCHEME_LSB +: 2]);
			s_d.range_sel        = wb_req.dat[fll_clock_pkg::CTRL_RANGE_BIT];
			s_d.reference_select = wb_req.dat[fll_clock_pkg::CTRL_REFSEL_BIT];
			if (!s_q.hgo_done)
			begin
				s_d.high_gain_select = wb_req.dat[fll_clock_pkg::CTRL_HGO_BIT];
				s_d.hgo_done         = 1'b1;
			end
		end
		if (wr_ctrl1)
		begin
			s_d.multiplier_field = wb_req.dat[fll_clock_pkg::CTRL_MFD_LSB +: 3];
			s_d.divider_field    = wb_req.dat[fll_clock_pkg::CTRL_RFD_LSB +: 3];
			if (wb_req.dat[fll_clock_pkg::CTRL_MFD_LSB +: 3] <= fll_clock_pkg::FIELD_MAX)
			begin
				s_d.n_fac = fll_clock_pkg::n_decode(wb_req.dat[fll_clock_pkg::CTRL_MFD_LSB +: 3]);
			end
			if (wb_req.dat[fll_clock_pkg::CTRL_RFD_LSB +: 3] <= fll_clock_pkg::FIELD_MAX)
			begin
				s_d.r_shift = wb_req.dat[fll_clock_pkg::CTRL_RFD_LSB +: 3];
			end
		end

		// oscillator gain only meaningful with the external reference selected
		s_d.hgo_eff = s_q.high_gain_select && s_q.reference_select;

		// output frequency description and power per scheme
		s_d.cfg.rshift = s_q.r_shift;
		unique case (s_q.scheme)
			fll_clock_pkg::SCHEME_SCM:
			begin
				s_d.cfg.src    = fll_clock_pkg::SRC_OSC;
				s_d.cfg.mult   = fll_clock_pkg::UNIT_MULT;
				s_d.cfg.prediv = fll_clock_pkg::UNIT_PREDIV;
				s_d.pwr        = '{irg_on: 1'b0, dco_on: 1'b1, dco_open_loop: 1'b1};
			end
			fll_clock_pkg::SCHEME_FBE:
			begin
				s_d.cfg.src    = fll_clock_pkg::SRC_EXT;
				s_d.cfg.mult   = fll_clock_pkg::UNIT_MULT;
				s_d.cfg.prediv = fll_clock_pkg::UNIT_PREDIV;
				s_d.pwr        = '{irg_on: 1'b0, dco_on: 1'b0, dco_open_loop: 1'b0};
			end
			fll_clock_pkg::SCHEME_FEI:
			begin
				s_d.cfg.src    = fll_clock_pkg::SRC_IRG;
				s_d.cfg.mult   = 10'(fll_clock_pkg::FEI_P * {6'h00, s_q.n_fac});
				s_d.cfg.prediv = fll_clock_pkg::FEI_PREDIV;
				s_d.pwr        = '{irg_on: 1'b1, dco_on: 1'b1, dco_open_loop: 1'b0};
			end
			fll_clock_pkg::SCHEME_FEE:
			begin
				s_d.cfg.src    = fll_clock_pkg::SRC_EXT;
				s_d.cfg.mult   = pn;
				s_d.cfg.prediv = fll_clock_pkg::UNIT_PREDIV;
				s_d.pwr        = '{irg_on: 1'b0, dco_on: 1'b1, dco_open_loop: 1'b0};
			end
		endcase

		// bus slave, one wait-free answer per request, unmapped reads zero
		s_d.ack = access;
		if (access)
		begin
			s_d.rdat = 32'h0000_0000;
			unique case (wb_req.adr)
				fll_clock_pkg::OFF_CTRL:
				begin
					s_d.rdat[fll_clock_pkg::CTRL_SCHEME_LSB +: 2] = s_q.scheme;
					s_d.rdat[fll_clock_pkg::CTRL_RANGE_BIT]       = s_q.range_sel;
					s_d.rdat[fll_clock_pkg::CTRL_REFSEL_BIT]      = s_q.reference_select;
					s_d.rdat[fll_clock_pkg::CTRL_HGO_BIT]         = s_q.high_gain_select;
					s_d.rdat[fll_clock_pkg::CTRL_MFD_LSB +: 3]    = s_q.multiplier_field;
					s_d.rdat[fll_clock_pkg::CTRL_RFD_LSB +: 3]    = s_q.divider_field;
				end
				fll_clock_pkg::OFF_STATUS:
				begin
					s_d.rdat[fll_clock_pkg::ST_LOCK_BIT]      = s_q.lock_s2;
					s_d.rdat[fll_clock_pkg::ST_FFE_BIT]       = ffe;
					s_d.rdat[fll_clock_pkg::ST_IRG_BIT]       = s_q.pwr.irg_on;
					s_d.rdat[fll_clock_pkg::ST_DCO_BIT]       = s_q.pwr.dco_on;
					s_d.rdat[fll_clock_pkg::ST_OPEN_BIT]      = s_q.pwr.dco_open_loop;
					s_d.rdat[fll_clock_pkg::ST_HGO_EFF_BIT]   = s_q.hgo_eff;
					s_d.rdat[fll_clock_pkg::ST_HGO_DONE_BIT]  = s_q.hgo_done;
					s_d.rdat[fll_clock_pkg::ST_N_LSB +: 4]    = s_q.n_fac;
					s_d.rdat[fll_clock_pkg::ST_RSHIFT_LSB +: 3] = s_q.r_shift;
				end
				fll_clock_pkg::OFF_FREQ:
				begin
					s_d.rdat[fll_clock_pkg::FQ_MULT_LSB +: 10]  = s_q.cfg.mult;
					s_d.rdat[fll_clock_pkg::FQ_PREDIV_LSB +: 4] = s_q.cfg.prediv;
					s_d.rdat[fll_clock_pkg::FQ_RSHIFT_LSB +: 3] = s_q.cfg.rshift;
					s_d.rdat[fll_clock_pkg::FQ_SRC_LSB +: 2]    = s_q.cfg.src;
				end
				default: s_d.rdat = 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			s_q                  <= '0;
			s_q.scheme           <= fll_clock_pkg::RST_SCHEME;
			s_q.multiplier_field <= fll_clock_pkg::RST_MFD;
			s_q.divider_field    <= fll_clock_pkg::RST_RFD;
			s_q.n_fac            <= fll_clock_pkg::RST_N;
			s_q.r_shift          <= fll_clock_pkg::RST_RSHIFT;
			s_q.ff_sel           <= fll_clock_pkg::FF_OFF;
			s_q.cfg.src          <= fll_clock_pkg::SRC_OSC;
			s_q.cfg.mult         <= fll_clock_pkg::UNIT_MULT;
			s_q.cfg.prediv       <= fll_clock_pkg::UNIT_PREDIV;
			s_q.pwr              <= '{irg_on: 1'b0, dco_on: 1'b1, dco_open_loop: 1'b1};
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign wb_rsp.ack                = s_q.ack;
	assign wb_rsp.dat                = s_q.rdat;
	assign internal_bus_clock        = s_q.bus_clk;
	assign fixed_freq_clock          = s_q.ff_clk;
	assign fixed_freq_enable         = ffe;
	assign generator_cfg             = s_q.cfg;
	assign power                     = s_q.pwr;
	assign oscillator_high_gain      = s_q.hgo_eff;
	assign rti_ref_clock             = s_q.ext_s3;
	assign alternate_converter_clock = s_q.ext_s3;
	assign local_self_clock          = s_q.self_clk;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [5:0] off_cnt_q;
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			off_cnt_q <= 6'h00;
		else if (ff_want != fll_clock_pkg::FF_OFF)
			off_cnt_q <= 6'h00;
		else if (off_cnt_q != 6'h3F)
			off_cnt_q <= off_cnt_q + 6'h01;
	end

	chk_ff_off_low: assert property (@(posedge clk_sys) disable iff (rst)
		(off_cnt_q == 6'h3F) |-> !fixed_freq_clock)
		else $error("fixed clock active in an off scheme");
	chk_ffe_needs_lock: assert property (@(posedge clk_sys) disable iff (rst)
		fixed_freq_enable |-> s_q.lock_s2 && (s_q.scheme == fll_clock_pkg::SCHEME_FEE))
		else $error("fixed enable without lock or outside loop-engaged external");
	chk_no_short_high: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(fixed_freq_clock) |=> fixed_freq_clock)
		else $error("shortened high phase on fixed clock");
	chk_hgo_once: assert property (@(posedge clk_sys) disable iff (rst)
		(s_q.hgo_done && wr_ctrl0) |=> $stable(s_q.high_gain_select))
		else $error("high gain select changed after first write");
	chk_hgo_gate: assert property (@(posedge clk_sys) disable iff (rst)
		!s_q.reference_select ##1 !s_q.reference_select |-> !oscillator_high_gain)
		else $error("high gain honoured without reference select");
	chk_n_twelve: assert property (@(posedge clk_sys) disable iff (rst)
		(wr_ctrl1 && wb_req.dat[fll_clock_pkg::CTRL_MFD_LSB +: 3] == 3'h4) |=> (s_q.n_fac == 4'hC))
		else $error("multiplier code 100 not decoded to 12");
	chk_reserved_keep: assert property (@(posedge clk_sys) disable iff (rst)
		(wr_ctrl1 && wb_req.dat[fll_clock_pkg::CTRL_RFD_LSB +: 3] > 3'h4) |=> $stable(s_q.r_shift))
		else $error("reserved divider code changed the factor");
	chk_fei_power: assert property (@(posedge clk_sys) disable iff (rst)
		(s_q.scheme == fll_clock_pkg::SCHEME_FEI)[*2] |-> power.irg_on && power.dco_on
		&& (generator_cfg.prediv == 4'h7))
		else $error("internal engaged scheme misconfigured");
	chk_ack_single: assert property (@(posedge clk_sys) disable iff (rst)
		wb_rsp.ack |=> !wb_rsp.ack)
		else $error("ack held longer than one cycle");

endmodule

`default_nettype wire

// *** src/fll_clock_pkg.sv ***
// constants, enumerations and carriers of the clock generation control block
// assumes a 20 MHz system clock and a classic Wishbone master with 32-bit data
package fll_clock_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_FREQ   = 8'h08;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRL_SCHEME_LSB = 0;
	localparam int CTRL_RANGE_BIT  = 2;
	localparam int CTRL_REFSEL_BIT = 3;
	localparam int CTRL_HGO_BIT    = 4;
	localparam int CTRL_MFD_LSB    = 8;
	localparam int CTRL_RFD_LSB    = 12;
	localparam int ST_LOCK_BIT     = 0;
	localparam int ST_FFE_BIT      = 1;
	localparam int ST_IRG_BIT      = 2;
	localparam int ST_DCO_BIT      = 3;
	localparam int ST_OPEN_BIT     = 4;
	localparam int ST_HGO_EFF_BIT  = 5;
	localparam int ST_HGO_DONE_BIT = 6;
	localparam int ST_N_LSB        = 8;
	localparam int ST_RSHIFT_LSB   = 12;
	localparam int FQ_MULT_LSB     = 0;
	localparam int FQ_PREDIV_LSB   = 16;
	localparam int FQ_RSHIFT_LSB   = 24;
	localparam int FQ_SRC_LSB      = 28;

	// ----------------------------------------------------------------
	// enumerations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {SCHEME_SCM, SCHEME_FEI, SCHEME_FBE, SCHEME_FEE} scheme_e;
	typedef enum logic [1:0] {FF_OFF, FF_BUS, FF_REF} ff_sel_e;
	typedef enum logic [1:0] {SRC_OSC, SRC_EXT, SRC_IRG} freq_src_e;

	// ----------------------------------------------------------------
	// reset values and factors
	// ----------------------------------------------------------------
	localparam scheme_e    RST_SCHEME     = SCHEME_SCM;
	localparam logic [2:0] RST_MFD        = 3'h0;
	localparam logic [2:0] RST_RFD        = 3'h0;
	localparam logic [3:0] RST_N          = 4'h4;
	localparam logic [2:0] RST_RSHIFT     = 3'h0;
	localparam logic [2:0] FIELD_MAX      = 3'h4;
	localparam logic [9:0] P_LOW_RANGE    = 10'h040;
	localparam logic [9:0] P_HIGH_RANGE   = 10'h001;
	localparam logic [9:0] FEI_P          = 10'h040;
	localparam logic [3:0] FEI_PREDIV     = 4'h7;
	localparam logic [3:0] UNIT_PREDIV    = 4'h1;
	localparam logic [9:0] UNIT_MULT      = 10'h001;
	localparam logic [9:0] FFE_RATIO      = 10'h004;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_s;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} wb_rsp_s;

	typedef struct packed {
		freq_src_e  src;
		logic [9:0] mult;
		logic [3:0] prediv;
		logic [2:0] rshift;
	} freq_cfg_s;

	typedef struct packed {
		logic irg_on;
		logic dco_on;
		logic dco_open_loop;
	} power_s;

	// multiplier field code to factor n, valid codes only
	function automatic logic [3:0] n_decode(input logic [2:0] code);
		logic [3:0] n;
		n = 4'h4 + {code, 1'b0};
		return n;
	endfunction

endpackage
